// file: shared/acb_pkg.sv
// register map, field layout and bus constants of the converter register bank
package acb_pkg;

   localparam int NREG = 19;

   // register addresses
   localparam logic [7:0] A_PWR_CTRL   = 8'h00;
   localparam logic [7:0] A_GAIN0      = 8'h01;
   localparam logic [7:0] A_GAIN1      = 8'h02;
   localparam logic [7:0] A_CH_SEL     = 8'h03;
   localparam logic [7:0] A_RES_LOW    = 8'h04;
   localparam logic [7:0] A_RES_MID    = 8'h05;
   localparam logic [7:0] A_RES_HIGH   = 8'h06;
   localparam logic [7:0] A_CONV0      = 8'h07;
   localparam logic [7:0] A_CONV1      = 8'h08;
   localparam logic [7:0] A_CONV_CLK   = 8'h09;
   localparam logic [7:0] A_DAC_HIGH   = 8'h0b;
   localparam logic [7:0] A_DAC_LOW    = 8'h0c;
   localparam logic [7:0] A_DAC_CTRL   = 8'h0d;
   localparam logic [7:0] A_SER_CTRL   = 8'h0e;
   localparam logic [7:0] A_SER_TMO    = 8'h10;
   localparam logic [7:0] A_IOSC       = 8'h11;
   localparam logic [7:0] A_XOSC       = 8'h12;

   // field positions
   localparam int CM_REF_EN_BIT  = 7;
   localparam int CONV_OFF_BIT   = 5;
   localparam int EOC_BIT        = 1;
   localparam int OSC_FLAG_BIT   = 1;
   localparam int DAC_EN_BIT     = 7;
   localparam int DAC_SRC_BIT    = 6;
   localparam int ATTEN_LSB      = 5;
   localparam int ATTEN_W        = 2;
   localparam int DAC_LOW_W      = 4;
   localparam int DAC_HIGH_W     = 8;

   // serial interface
   localparam logic [6:0] DEV_ADDR_BASE = 7'h2c;
   localparam int         ADDR_PIN_W    = 2;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [3:0] LAST_TX_BIT   = 4'h7;

   typedef enum logic [3:0] {
      S_IDLE, S_ADDR, S_ADDR_ACK, S_REG, S_REG_ACK,
      S_WDATA, S_WDATA_ACK, S_RDATA, S_RDATA_ACK
   } acb_i2c_st_t;

   // bits the host may write
   function automatic logic [7:0] acb_wmask(input logic [7:0] a);
      logic [7:0] m;
      m = 8'h00;
      if (a == A_PWR_CTRL) m = 8'h80;
      else if (a == A_GAIN0) m = 8'h7f;
      else if (a == A_GAIN1) m = 8'h7e;
      else if (a == A_CH_SEL) m = 8'h3f;
      else if (a == A_CONV0) m = 8'hff;
      else if (a == A_CONV1) m = 8'hfe;
      else if (a == A_CONV_CLK) m = 8'h1f;
      else if (a == A_DAC_HIGH) m = 8'hff;
      else if (a == A_DAC_LOW) m = 8'h0f;
      else if (a == A_DAC_CTRL) m = 8'hc0;
      else if (a == A_SER_CTRL) m = 8'h8c;
      else if (a == A_SER_TMO) m = 8'hff;
      else if (a == A_IOSC) m = 8'h05;
      else if (a == A_XOSC) m = 8'h05;
      return m;
   endfunction

   // power-on values
   function automatic logic [7:0] acb_reset(input logic [7:0] a);
      logic [7:0] v;
      v = 8'h00;
      if (a == A_CONV0) v = 8'h20;
      else if (a == A_IOSC) v = 8'h01;
      return v;
   endfunction

endpackage

// file: hdl/acb_pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module acb_pin_sync
   import acb_pkg::*;
#(
   parameter int W = 4
) (
   // clock and reset
   input  wire logic         CLK,
   input  wire logic         RST_N,
   // pins
   input  wire logic [W-1:0] PIN,
   // filtered levels
   output      logic [W-1:0] LEVEL
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] lvl;
   } acb_sync_t;

   acb_sync_t st_q;
   acb_sync_t st_d;

   always_comb begin
      st_d    = st_q;
      st_d.s1 = PIN;
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
      for (int i = 0; i < W; i++) begin
         if (st_q.s2[i] == st_q.s3[i]) begin
            st_d.lvl[i] = st_q.s3[i];
         end
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         st_q <= '1;
      end else begin
         st_q <= st_d;
      end
   end

   assign LEVEL = st_q.lvl;

endmodule

// file: hdl/acb_reg_bank.sv
// converter register bank with its serial slave port
// Functional notes
// - every host command and data byte reaches the registers over the serial slave port.
// - power-on reset loads each implemented bit with its listed value, converter control 0 with 8'h20.
// - each conversion result is stored as 24 bits over result low, middle and high.
// - the enable bit in power control switches the common-mode reference on and off.
// - a disabled reference draws no power and floats, and the low seven power control bits read zero.
// - the attenuation field passes the external reference at gain one, one half or one quarter.
// - the 12-bit dac code is high register bits 11..4 plus low register bits 3..0.
// - a low register write only fills a shadow that goes live when the high register is written.
// - bits 7..4 of the dac low register read zero.
// - dac control bit 7 enables the reference dac.
// - dac control bit 6 picks the analog supply (0) or the common-mode reference (1).
// - dac control bits 5..0 read zero.
// - the bandgap is off only with converter off set and reference enable clear.
`timescale 1ns/10ps
module acb_reg_bank
   import acb_pkg::*;
#(
   parameter logic [6:0] SLAVE_BASE = DEV_ADDR_BASE
) (
   // clock and reset
   input  wire logic        CLK,
   input  wire logic        RST_N,
   // serial bus pins
   input  wire logic        SCL_IN,
   input  wire logic        SDA_IN,
   output      logic        SDA_OUT,
   output      logic        SDA_OE,
   // slave address straps
   input  wire logic        ADDR_SEL1,
   input  wire logic        ADDR_SEL2,
   // converter result
   input  wire logic [23:0] RESULT_DATA,
   input  wire logic        RESULT_VALID,
   // oscillator status
   input  wire logic        INT_OSC_STABLE,
   input  wire logic        XTAL_OSC_STABLE,
   // reference and dac controls
   output      logic        COMMON_MODE_REF_ENABLE,
   output      logic        BANDGAP_ON,
   output      logic [1:0]  REFERENCE_ATTENUATION,
   output      logic [11:0] REF_DAC_CODE,
   output      logic        REF_DAC_ENABLE,
   output      logic        REF_DAC_SOURCE_SELECT,
   // raw control registers
   output      logic [7:0]  GAIN_CONTROL_0,
   output      logic [7:0]  GAIN_CONTROL_1,
   output      logic [7:0]  INPUT_CHANNEL_SELECT,
   output      logic [7:0]  CONVERTER_CONTROL_0,
   output      logic [7:0]  CONVERTER_CONTROL_1,
   output      logic [7:0]  CONVERTER_CLOCK_SELECT,
   output      logic [7:0]  SERIAL_INTERFACE_CONTROL,
   output      logic [7:0]  SERIAL_TIMEOUT_CONTROL,
   output      logic [7:0]  INTERNAL_OSC_CONTROL,
   output      logic [7:0]  CRYSTAL_OSC_CONTROL
);

   typedef struct packed {
      logic [NREG-1:0][7:0]   regs;
      logic [DAC_LOW_W-1:0]   dal_act;
      acb_i2c_st_t            st;
      logic [3:0]             bitcnt;
      logic [7:0]             shift;
      logic [7:0]             tx;
      logic [7:0]             ptr;
      logic                   rw;
      logic                   sda_oe;
      logic                   scl_p;
      logic                   sda_p;
   } acb_state_t;

   acb_state_t st_q;
   acb_state_t st_d;

   logic [3:0] pins;
   logic       scl;
   logic       sda;
   logic [6:0] my_addr;

   acb_pin_sync #(
      .W(4)
   ) u_sync (
      .CLK   (CLK),
      .RST_N (RST_N),
      .PIN   ({ADDR_SEL2, ADDR_SEL1, SDA_IN, SCL_IN}),
      .LEVEL (pins)
   );

   assign scl     = pins[0];
   assign sda     = pins[1];
   assign my_addr = {SLAVE_BASE[6:ADDR_PIN_W], pins[3], pins[2]};

   // register read with unimplemented bits forced low
   function automatic logic [7:0] rd(input acb_state_t s,
                                     input logic [7:0] a);
      logic [7:0] v;
      v = 8'h00;
      if (a < 8'(NREG)) begin
         v = s.regs[a[4:0]] & acb_wmask(a);
         if (a == A_RES_LOW || a == A_RES_MID || a == A_RES_HIGH) begin
            v = s.regs[a[4:0]];
         end else if (a == A_CONV1) begin
            v[EOC_BIT] = s.regs[a[4:0]][EOC_BIT];
         end else if (a == A_IOSC) begin
            v[OSC_FLAG_BIT] = INT_OSC_STABLE;
         end else if (a == A_XOSC) begin
            v[OSC_FLAG_BIT] = XTAL_OSC_STABLE;
         end
      end
      return v;
   endfunction

   logic start_ev;
   logic stop_ev;
   logic scl_rise;
   logic scl_fall;

   assign start_ev = st_q.scl_p & scl & st_q.sda_p & ~sda;
   assign stop_ev  = st_q.scl_p & scl & ~st_q.sda_p & sda;
   assign scl_rise = ~st_q.scl_p & scl;
   assign scl_fall = st_q.scl_p & ~scl;

   always_comb begin
      logic       wr_en;
      logic [7:0] wa;
      logic [7:0] wd;
      wr_en    = 1'b0;
      wa       = 8'h00;
      wd       = 8'h00;
      st_d       = st_q;
      st_d.scl_p = scl;
      st_d.sda_p = sda;

      // serial slave sequencing
      if (start_ev) begin
         st_d.st     = S_ADDR;
         st_d.bitcnt = 4'h0;
         st_d.sda_oe = 1'b0;
      end else if (stop_ev) begin
         st_d.st     = S_IDLE;
         st_d.sda_oe = 1'b0;
      end else if (scl_rise) begin
         case (st_q.st)
            S_ADDR, S_REG, S_WDATA: begin
               st_d.shift  = {st_q.shift[6:0], sda};
               st_d.bitcnt = st_q.bitcnt + 4'h1;
            end
            S_RDATA: begin
               st_d.bitcnt = st_q.bitcnt + 4'h1;
            end
            S_RDATA_ACK: begin
               if (sda) begin
                  st_d.st = S_IDLE;
               end
            end
            default: begin
            end
         endcase
      end else if (scl_fall) begin
         case (st_q.st)
            S_ADDR: begin
               if (st_q.bitcnt == BITS_PER_BYTE) begin
                  if (st_q.shift[7:1] == my_addr) begin
                     st_d.rw     = st_q.shift[0];
                     st_d.sda_oe = 1'b1;
                     st_d.st     = S_ADDR_ACK;
                  end else begin
                     st_d.st = S_IDLE;
                  end
               end
            end
            S_ADDR_ACK: begin
               st_d.bitcnt = 4'h0;
               if (st_q.rw) begin
                  st_d.tx     = rd(st_q, st_q.ptr);
                  st_d.sda_oe = ~st_d.tx[7];
                  st_d.ptr    = st_q.ptr + 8'h01;
                  st_d.st     = S_RDATA;
               end else begin
                  st_d.sda_oe = 1'b0;
                  st_d.st     = S_REG;
               end
            end
            S_REG: begin
               if (st_q.bitcnt == BITS_PER_BYTE) begin
                  st_d.ptr    = st_q.shift;
                  st_d.sda_oe = 1'b1;
                  st_d.st     = S_REG_ACK;
               end
            end
            S_REG_ACK, S_WDATA_ACK: begin
               st_d.sda_oe = 1'b0;
               st_d.bitcnt = 4'h0;
               st_d.st     = S_WDATA;
            end
            S_WDATA: begin
               if (st_q.bitcnt == BITS_PER_BYTE) begin
                  wr_en       = 1'b1;
                  wa          = st_q.ptr;
                  wd          = st_q.shift;
                  st_d.ptr    = st_q.ptr + 8'h01;
                  st_d.sda_oe = 1'b1;
                  st_d.st     = S_WDATA_ACK;
               end
            end
            S_RDATA: begin
               if (st_q.bitcnt == BITS_PER_BYTE) begin
                  st_d.sda_oe = 1'b0;
                  st_d.st     = S_RDATA_ACK;
               end else if (st_q.bitcnt <= LAST_TX_BIT) begin
                  st_d.tx     = {st_q.tx[6:0], 1'b0};
                  st_d.sda_oe = ~st_d.tx[7];
               end
            end
            S_RDATA_ACK: begin
               st_d.bitcnt = 4'h0;
               st_d.tx     = rd(st_q, st_q.ptr);
               st_d.sda_oe = ~st_d.tx[7];
               st_d.ptr    = st_q.ptr + 8'h01;
               st_d.st     = S_RDATA;
            end
            default: begin
               st_d.sda_oe = 1'b0;
            end
         endcase
      end

      // host write into the register array
      if (wr_en && wa < 8'(NREG)) begin
         st_d.regs[wa[4:0]] = (st_q.regs[wa[4:0]] & ~acb_wmask(wa))
                              | (wd & acb_wmask(wa));
         if (wa == A_CONV1) begin
            st_d.regs[wa[4:0]][EOC_BIT] = wd[EOC_BIT];
         end
         if (wa == A_DAC_HIGH) begin
            st_d.dal_act = st_q.regs[A_DAC_LOW[4:0]][DAC_LOW_W-1:0];
         end
      end

      // conversion result capture, set of end flag wins over a clear
      if (RESULT_VALID) begin
         st_d.regs[A_RES_LOW[4:0]]  = RESULT_DATA[7:0];
         st_d.regs[A_RES_MID[4:0]]  = RESULT_DATA[15:8];
         st_d.regs[A_RES_HIGH[4:0]] = RESULT_DATA[23:16];
         st_d.regs[A_CONV1[4:0]][EOC_BIT] = 1'b1;
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         st_q        <= '0;
         st_q.st     <= S_IDLE;
         st_q.scl_p  <= 1'b1;
         st_q.sda_p  <= 1'b1;
         st_q.regs[A_CONV0[4:0]] <= acb_reset(A_CONV0);
         st_q.regs[A_IOSC[4:0]]  <= acb_reset(A_IOSC);
      end else begin
         st_q <= st_d;
      end
   end

   // bus pin drive, open drain
   assign SDA_OUT = 1'b0;
   assign SDA_OE  = st_q.sda_oe;

   // analog control decode
   assign COMMON_MODE_REF_ENABLE =
      st_q.regs[A_PWR_CTRL[4:0]][CM_REF_EN_BIT];
   assign BANDGAP_ON = ~(st_q.regs[A_CONV0[4:0]][CONV_OFF_BIT]
      & ~st_q.regs[A_PWR_CTRL[4:0]][CM_REF_EN_BIT]);
   assign REFERENCE_ATTENUATION =
      st_q.regs[A_GAIN0[4:0]][ATTEN_LSB +: ATTEN_W];
   assign REF_DAC_CODE = {st_q.regs[A_DAC_HIGH[4:0]], st_q.dal_act};
   assign REF_DAC_ENABLE = st_q.regs[A_DAC_CTRL[4:0]][DAC_EN_BIT];
   assign REF_DAC_SOURCE_SELECT =
      st_q.regs[A_DAC_CTRL[4:0]][DAC_SRC_BIT];

   assign GAIN_CONTROL_0           = st_q.regs[A_GAIN0[4:0]];
   assign GAIN_CONTROL_1           = st_q.regs[A_GAIN1[4:0]];
   assign INPUT_CHANNEL_SELECT     = st_q.regs[A_CH_SEL[4:0]];
   assign CONVERTER_CONTROL_0      = st_q.regs[A_CONV0[4:0]];
   assign CONVERTER_CONTROL_1      = st_q.regs[A_CONV1[4:0]];
   assign CONVERTER_CLOCK_SELECT   = st_q.regs[A_CONV_CLK[4:0]];
   assign SERIAL_INTERFACE_CONTROL = st_q.regs[A_SER_CTRL[4:0]];
   assign SERIAL_TIMEOUT_CONTROL   = st_q.regs[A_SER_TMO[4:0]];
   assign INTERNAL_OSC_CONTROL     = st_q.regs[A_IOSC[4:0]];
   assign CRYSTAL_OSC_CONTROL      = st_q.regs[A_XOSC[4:0]];

endmodule

// file: bench/acb_reg_bank_props.sv
// port assertions for the converter register bank
`timescale 1ns/10ps
module acb_reg_bank_props (
   // clock and reset
   input wire logic        CLK,
   input wire logic        RST_N,
   // serial and converter
   input wire logic        SCL_IN,
   input wire logic        SDA_OUT,
   input wire logic        SDA_OE,
   input wire logic        RESULT_VALID,
   // controls
   input wire logic        COMMON_MODE_REF_ENABLE,
   input wire logic        BANDGAP_ON,
   input wire logic [1:0]  REFERENCE_ATTENUATION,
   input wire logic [11:0] REF_DAC_CODE,
   input wire logic [7:0]  GAIN_CONTROL_0,
   input wire logic [7:0]  GAIN_CONTROL_1,
   input wire logic [7:0]  INPUT_CHANNEL_SELECT,
   input wire logic [7:0]  CONVERTER_CONTROL_0,
   input wire logic [7:0]  CONVERTER_CONTROL_1,
   input wire logic [7:0]  INTERNAL_OSC_CONTROL
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);

   bandgap_table_a: assert property (
      BANDGAP_ON == !(CONVERTER_CONTROL_0[5] && !COMMON_MODE_REF_ENABLE))
      else $error("bandgap state wrong");
   atten_field_a: assert property (
      REFERENCE_ATTENUATION == GAIN_CONTROL_0[6:5])
      else $error("attenuation not from gain control");
   unimpl_bits_a: assert property (
      !GAIN_CONTROL_0[7] && !GAIN_CONTROL_1[7] && !GAIN_CONTROL_1[0] &&
      INPUT_CHANNEL_SELECT[7:6] == 2'b00 && !CONVERTER_CONTROL_1[0] &&
      INTERNAL_OSC_CONTROL[7:3] == 5'h00)
      else $error("unimplemented bit set");
   dac_quiet_a: assert property (
      SCL_IN [*8] |=> $stable(REF_DAC_CODE) && $stable(COMMON_MODE_REF_ENABLE))
      else $error("control changed with bus quiet");
   end_flag_a: assert property (
      RESULT_VALID |=> CONVERTER_CONTROL_1[1])
      else $error("end flag not set");
   sda_low_a: assert property (
      SDA_OUT == 1'b0)
      else $error("data pin driven high");
   sda_edge_a: assert property (
      $changed(SDA_OE) |-> !SCL_IN)
      else $error("data line moved with clock high");
   reset_vals_a: assert property (
      $rose(RST_N) |-> CONVERTER_CONTROL_0 == 8'h20 &&
      GAIN_CONTROL_0 == 8'h00 && REF_DAC_CODE == 12'h000 &&
      !COMMON_MODE_REF_ENABLE && !BANDGAP_ON && INTERNAL_OSC_CONTROL == 8'h01)
      else $error("wrong value after reset");
endmodule

bind acb_reg_bank acb_reg_bank_props chk (
   .CLK(CLK), .RST_N(RST_N), .SCL_IN(SCL_IN), .SDA_OUT(SDA_OUT),
   .SDA_OE(SDA_OE), .RESULT_VALID(RESULT_VALID),
   .COMMON_MODE_REF_ENABLE(COMMON_MODE_REF_ENABLE), .BANDGAP_ON(BANDGAP_ON),
   .REFERENCE_ATTENUATION(REFERENCE_ATTENUATION),
   .REF_DAC_CODE(REF_DAC_CODE), .GAIN_CONTROL_0(GAIN_CONTROL_0),
   .GAIN_CONTROL_1(GAIN_CONTROL_1), .INPUT_CHANNEL_SELECT(INPUT_CHANNEL_SELECT),
   .CONVERTER_CONTROL_0(CONVERTER_CONTROL_0),
   .CONVERTER_CONTROL_1(CONVERTER_CONTROL_1),
   .INTERNAL_OSC_CONTROL(INTERNAL_OSC_CONTROL)
);

// file: bench/acb_host_model.sv
// behavioural serial bus host for the register bank
`timescale 1ns/10ps
module acb_host_model (
   // clock
   input  wire logic clk,
   // resolved data line
   input  wire logic sda,
   // driven lines
   output      logic scl,
   output      logic sda_low
);
   logic [6:0] dev = 7'h2c;
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task automatic hold(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic put_bit(input logic b);
      sda_low <= ~b;
      hold(5);
      scl <= 1'b1;
      hold(10);
      scl <= 1'b0;
      hold(5);
   endtask
   task automatic get_bit(output logic b);
      sda_low <= 1'b0;
      hold(5);
      scl <= 1'b1;
      hold(5);
      b = sda;
      hold(5);
      scl <= 1'b0;
      hold(5);
   endtask
   task automatic start();
      sda_low <= 1'b0;
      hold(5);
      scl <= 1'b1;
      hold(10);
      sda_low <= 1'b1;
      hold(10);
      scl <= 1'b0;
      hold(5);
   endtask
   task automatic stop();
      sda_low <= 1'b1;
      hold(5);
      scl <= 1'b1;
      hold(10);
      sda_low <= 1'b0;
      hold(10);
   endtask
   task automatic put_byte(input logic [7:0] v, output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--) put_bit(v[i]);
      get_bit(b);
      ack = ~b;
   endtask
   task automatic get_byte(output logic [7:0] v);
      logic b;
      for (int i = 7; i >= 0; i--) begin
         get_bit(b);
         v[i] = b;
      end
      put_bit(1'b1);
   endtask
   // all register traffic goes over the two-wire bus
   task automatic wr(input logic [7:0] a, d, output logic ok);
      logic a0, a1, a2;
      start();
      put_byte({dev, 1'b0}, a0);
      put_byte(a, a1);
      put_byte(d, a2);
      stop();
      ok = a0 & a1 & a2;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
      logic a0, a1, a2;
      start();
      put_byte({dev, 1'b0}, a0);
      put_byte(a, a1);
      start();
      put_byte({dev, 1'b1}, a2);
      get_byte(d);
      stop();
      ok = a0 & a1 & a2;
   endtask
endmodule

// file: bench/tb_adc_config_register_bank.sv
// self-checking bench for the converter register bank
`timescale 1ns/10ps
module tb_adc_config_register_bank
   import acb_pkg::*;
;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        sel1 = 1'b0;
   logic        sel2 = 1'b0;
   logic        res_valid = 1'b0;
   logic [23:0] res_data = 24'h000000;
   logic        int_st, xtal_st, scl, host_low, sda_oe, ack;
   logic        cm_en, bg_on, dac_en, dac_src;
   logic [1:0]  atten;
   logic [11:0] dac_code;
   logic [7:0]  g0;
   wire  [71:0] raw;
   logic [7:0]  raw_a [0:8] = '{A_GAIN1, A_CH_SEL, A_CONV0, A_CONV1,
      A_CONV_CLK, A_SER_CTRL, A_SER_TMO, A_IOSC, A_XOSC};
   logic [7:0]  m [0:31];
   logic [23:0] res = 24'h000000;
   logic        eoc = 1'b0;
   logic [3:0]  live = 4'h0;
   logic [7:0]  hot [0:2] = '{A_PWR_CTRL, A_DAC_LOW, A_DAC_CTRL};
   int          bad_count = 0;
   int          samples_checked = 0;
   int          seed = 32'h0421;
   wire         sda = ~(host_low | sda_oe);

   always #50 clk = ~clk;

   acb_reg_bank dut (
      .CLK(clk), .RST_N(rst_n), .SCL_IN(scl), .SDA_IN(sda),
      .SDA_OUT(), .SDA_OE(sda_oe), .ADDR_SEL1(sel1), .ADDR_SEL2(sel2),
      .RESULT_DATA(res_data), .RESULT_VALID(res_valid),
      .INT_OSC_STABLE(int_st), .XTAL_OSC_STABLE(xtal_st),
      .COMMON_MODE_REF_ENABLE(cm_en), .BANDGAP_ON(bg_on),
      .REFERENCE_ATTENUATION(atten), .REF_DAC_CODE(dac_code),
      .REF_DAC_ENABLE(dac_en), .REF_DAC_SOURCE_SELECT(dac_src),
      .GAIN_CONTROL_0(g0), .GAIN_CONTROL_1(raw[7:0]),
      .INPUT_CHANNEL_SELECT(raw[15:8]), .CONVERTER_CONTROL_0(raw[23:16]),
      .CONVERTER_CONTROL_1(raw[31:24]),
      .CONVERTER_CLOCK_SELECT(raw[39:32]),
      .SERIAL_INTERFACE_CONTROL(raw[47:40]),
      .SERIAL_TIMEOUT_CONTROL(raw[55:48]),
      .INTERNAL_OSC_CONTROL(raw[63:56]),
      .CRYSTAL_OSC_CONTROL(raw[71:64])
   );
   acb_host_model host (.clk(clk), .sda(sda), .scl(scl), .sda_low(host_low));

   function automatic logic [7:0] wmask(input logic [7:0] a);
      case (a)
         8'h00: return 8'h80;
         8'h01: return 8'h7f;
         8'h02: return 8'h7e;
         8'h03: return 8'h3f;
         8'h07, 8'h0b, 8'h10: return 8'hff;
         8'h08: return 8'hfc;
         8'h09: return 8'h1f;
         8'h0c: return 8'h0f;
         8'h0d: return 8'hc0;
         8'h0e: return 8'h8c;
         8'h11, 8'h12: return 8'h05;
         default: return 8'h00;
      endcase
   endfunction
   function automatic logic [7:0] exp_rd(input logic [7:0] a);
      logic [7:0] v;
      v = m[a[4:0]] & wmask(a);
      if (a == 8'h04) v = res[7:0];
      if (a == 8'h05) v = res[15:8];
      if (a == 8'h06) v = res[23:16];
      if (a == 8'h08) v[1] = eoc;
      if (a == 8'h11) v[1] = int_st;
      if (a == 8'h12) v[1] = xtal_st;
      return v;
   endfunction
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      logic ok;
      if (a == 8'h08) d[1] = 1'b0;
      host.wr(a, d, ok);
      chk(ok, 1'b1);
      m[a[4:0]] = d;
      if (a == 8'h08) eoc = 1'b0;
      if (a == 8'h0b) live = m[12][3:0];
   endtask
   task automatic rchk(input logic [7:0] a);
      logic [7:0] d;
      logic       ok;
      host.rd(a, d, ok);
      chk({ok, d}, {1'b1, exp_rd(a)});
   endtask
   task automatic chk_out();
      logic [7:0] v;
      chk(cm_en, m[0][7]);
      chk(bg_on, !(m[7][5] && !m[0][7]));
      chk(atten, m[1][6:5]);
      chk(dac_code, {m[11], live});
      chk({dac_en, dac_src}, m[13][7:6]);
      chk(g0, m[1] & 8'h7f);
      for (int i = 0; i < 9; i++) begin
         v = m[raw_a[i][4:0]] & wmask(raw_a[i]);
         if (raw_a[i] == A_CONV1) v[1] = eoc;
         chk(raw[i*8 +: 8], v);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   initial begin
      {int_st, xtal_st} <= 2'($random(seed));
      for (int i = 0; i < 32; i++) m[i] = 8'h00;
      m[7] = 8'h20;
      m[17] = 8'h01;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      chk_out();
      for (int a = 0; a < 20; a++) rchk(8'(a));
      $display("test reset values done");
      res_data <= 24'($random(seed));
      res_valid <= 1'b1;
      @(posedge clk);
      res_valid <= 1'b0;
      res = res_data;
      eoc = 1'b1;
      for (int a = 4; a < 9; a++) rchk(8'(a));
      $display("test result done");
      for (int a = 0; a < 20; a++) wreg(8'(a), 8'($random(seed)));
      chk_out();
      for (int a = 0; a < 20; a++) rchk(8'(a));
      wreg(A_DAC_HIGH, m[11]);
      chk_out();
      for (int i = 0; i < 3; i++) begin
         wreg(hot[i], 8'hff);
         rchk(hot[i]);
      end
      $display("test register map done");
      for (int i = 0; i < 4; i++) begin
         wreg(A_PWR_CTRL, {i[0], 7'h00});
         wreg(A_CONV0, {2'b00, i[1], 5'h00});
         wreg(A_GAIN0, {1'b0, i[1:0], 5'h00});
         chk_out();
      end
      $display("test power table done");
      sel1 <= 1'b1;
      {int_st, xtal_st} <= ~{int_st, xtal_st};
      repeat (4) @(posedge clk);
      host.wr(A_GAIN1, 8'h55, ack);
      chk(ack, 1'b0);
      host.dev = 7'h2d;
      wreg(A_CH_SEL, 8'h2a);
      {sel2, sel1} <= 2'b10;
      repeat (4) @(posedge clk);
      host.dev = 7'h2e;
      wreg(A_CONV_CLK, 8'h13);
      host.dev = 7'h2c;
      sel2 <= 1'b0;
      repeat (4) @(posedge clk);
      for (int a = 1; a < 4; a++) rchk(8'(a));
      rchk(A_CONV_CLK);
      chk_out();
      rchk(A_IOSC);
      rchk(A_XOSC);
      $display("test strap address done");
      end_sim();
   end

   initial begin
      repeat (90000) @(posedge clk);
      bad_count++;
      end_sim();
   end
endmodule
